// file: logic/hsc_top.sv
// Homing sequencer driven by a bit-mapped configuration word.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Function 2: search in bit-4 direction, reverse at home switch.
// - Function 2, bit 5 clear: home switch edge is home.
// - Function 2, bit 5 set: index pulse is home, bit 6 picks which.
// - Function 2: limit before home switch is an error.
// - Function 3: like 2, but a limit reverses the search.
// - Momentary switch: bit 8 set uses negative edge, else positive.
// - Function 4: move in initial direction until current threshold reached.
// - Hard stop: keep pressing until the home delay expires.
// - Hard stop, bit 5 set: back away after delay, take next index.
// - Bit 4 clear starts positive, set starts negative.
// - Bit 5 set references home to an index pulse.
// - Functions 2 and 3, bit 6 set: index on initial-direction side of home switch edge.
// - Bit 7 set captures falling index edge, else rising.
// - Bit 9 set moves to zero after homing; clear only sets zero.
// - Bit 10 set leaves actual position unadjusted.
// - Bit 10 set still records the would-be adjustment.
// - Bit 10 set suppresses the move to zero.
// - Bit 11 set writes 15 into stored home configuration.
// - Bit 11 set stores offset calibrating the absolute encoder.
// - Function 0, bit 5 clear: present position is home.
// - Function 1: move to a limit, then move back out.
// - Zero position is home position plus signed home offset.
// - Hard stop move limits current 25 percent above threshold.
module hsc_top #(
    parameter int POS_W = 32,
    parameter int CUR_W = 16
) (
    // Clock and reset
    input  wire logic             CORE_CLK,
    input  wire logic             RST,
    // Register port
    input  wire logic [3:0]       ADDR,
    input  wire logic [31:0]      WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output logic      [31:0]      RDATA,
    // Motor side
    input  wire logic [POS_W-1:0] POS_ACTUAL,
    input  wire logic [CUR_W-1:0] CUR_ACTUAL,
    input  wire logic [CUR_W-1:0] CUR_THRESH,
    output logic                  MOVE_EN,
    output logic                  MOVE_NEG,
    output logic                  SLOW,
    output logic      [CUR_W-1:0] CUR_LIMIT,
    output logic                  CUR_LIMIT_EN,
    output logic                  GOTO_ZERO,
    output logic                  POS_LOAD,
    output logic      [POS_W-1:0] POS_LOAD_VAL,
    // Sensor pins
    input  wire logic             INDEX_PIN,
    input  wire logic             HOME_PIN,
    input  wire logic             LIM_POS_PIN,
    input  wire logic             LIM_NEG_PIN,
    input  wire logic             ZERO_REACHED,
    // Status
    output logic                  BUSY,
    output logic                  DONE,
    output logic                  ERROR
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [4:0] pin_a_q;
    logic [4:0] pin_b_q;
    logic [4:0] pin_c_q;
    wire  [4:0] pins = {ZERO_REACHED, LIM_NEG_PIN, LIM_POS_PIN, HOME_PIN, INDEX_PIN};

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            pin_a_q <= 5'h00;
            pin_b_q <= 5'h00;
            pin_c_q <= 5'h00;
        end
        else
        begin
            pin_a_q <= pins;
            pin_b_q <= pin_a_q;
            pin_c_q <= pin_b_q;
        end
    end

    logic [15:0]      cfg_q;
    hsc_pkg::hsc_state_t st_q;
    logic             dir_q;

    wire idx_rise  = pin_b_q[0] & ~pin_c_q[0];
    wire idx_fall  = ~pin_b_q[0] & pin_c_q[0];
    wire idx_edge  = cfg_q[hsc_pkg::CFG_IFALL_BIT] ? idx_fall : idx_rise;
    wire home_rise = pin_b_q[1] & ~pin_c_q[1];
    wire home_fall = ~pin_b_q[1] & pin_c_q[1];
    wire home_lvl  = pin_b_q[1];
    wire home_sel  = cfg_q[hsc_pkg::CFG_HNEG_BIT] ? home_fall : home_rise;
    wire lim_hit   = dir_q ? pin_b_q[3] : pin_b_q[2];
    wire zero_done = pin_b_q[4];

    // ************************************************************
    // Registers
    // ************************************************************
    logic             start;
    logic [31:0]      offset_q;
    logic [15:0]      delay_ms_q;
    logic [31:0]      adjust_q;
    logic [15:0]      nv_cfg_q;
    logic [31:0]      nv_ofs_q;
    logic [31:0]      zero_q;
    logic [POS_W-1:0] home_pos_q;

    assign start = WR && ADDR == hsc_pkg::ADDR_CONTROL && WDATA[0];

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            cfg_q      <= hsc_pkg::CONFIG_RESET;
            offset_q   <= 32'h0000_0000;
            delay_ms_q <= 16'h0000;
        end
        else if (WR)
        begin
            if (ADDR == hsc_pkg::ADDR_CONFIG)
                cfg_q <= WDATA[15:0];
            if (ADDR == hsc_pkg::ADDR_OFFSET)
                offset_q <= WDATA;
            if (ADDR == hsc_pkg::ADDR_DELAY)
                delay_ms_q <= WDATA[15:0];
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            RDATA <= 32'h0000_0000;
        else if (RD)
        begin
            unique case (ADDR)
                hsc_pkg::ADDR_CONFIG: RDATA <= {16'h0000, cfg_q};
                hsc_pkg::ADDR_STATUS: RDATA <= {25'h0, 4'(st_q), ERROR, DONE, BUSY};
                hsc_pkg::ADDR_OFFSET: RDATA <= offset_q;
                hsc_pkg::ADDR_DELAY:  RDATA <= {16'h0000, delay_ms_q};
                hsc_pkg::ADDR_ADJUST: RDATA <= adjust_q;
                hsc_pkg::ADDR_NV_CFG: RDATA <= {16'h0000, nv_cfg_q};
                hsc_pkg::ADDR_NV_OFS: RDATA <= nv_ofs_q;
                hsc_pkg::ADDR_ZERO:   RDATA <= zero_q;
                default:              RDATA <= 32'h0000_0000;
            endcase
        end
        else
            RDATA <= 32'h0000_0000;
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    logic [31:0] dly_cnt_q;
    logic        found_q;
    wire  [31:0] dly_target = 32'(delay_ms_q) * 32'(hsc_pkg::MS_CYCLES);
    wire  [3:0]  func = cfg_q[hsc_pkg::CFG_FUNC_LSB +: 4];
    wire         use_idx = cfg_q[hsc_pkg::CFG_INDEX_BIT];
    wire         noadj = cfg_q[hsc_pkg::CFG_NOADJ_BIT];
    wire  [31:0] zero_calc = 32'(home_pos_q) + offset_q;

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            st_q        <= hsc_pkg::ST_IDLE;
            dir_q       <= 1'b0;
            found_q     <= 1'b0;
            dly_cnt_q   <= 32'h0000_0000;
            home_pos_q  <= '0;
        end
        else
        begin
            unique case (st_q)
                hsc_pkg::ST_IDLE:
                    if (start)
                    begin
                        dir_q   <= cfg_q[hsc_pkg::CFG_DIR_BIT];
                        found_q <= 1'b0;
                        dly_cnt_q <= 32'h0000_0000;
                        unique case (func)
                            hsc_pkg::FUNC_IMMEDIATE:
                                if (use_idx)
                                    st_q <= hsc_pkg::ST_INDEX;
                                else
                                begin
                                    home_pos_q <= POS_ACTUAL;
                                    st_q <= hsc_pkg::ST_FINISH;
                                end
                            hsc_pkg::FUNC_LIMIT, hsc_pkg::FUNC_SWITCH,
                            hsc_pkg::FUNC_MOMENTARY, hsc_pkg::FUNC_HARDSTOP:
                                st_q <= hsc_pkg::ST_SEARCH;
                            default:
                                st_q <= hsc_pkg::ST_ERROR;
                        endcase
                    end
                hsc_pkg::ST_SEARCH:
                    if (func == hsc_pkg::FUNC_HARDSTOP)
                    begin
                        if (CUR_ACTUAL >= CUR_THRESH)
                            st_q <= hsc_pkg::ST_PRESS;
                    end
                    else if (func == hsc_pkg::FUNC_LIMIT)
                    begin
                        if (lim_hit)
                        begin
                            dir_q <= ~dir_q;
                            st_q  <= hsc_pkg::ST_BACKOFF;
                        end
                    end
                    else if (home_lvl)
                    begin
                        dir_q <= ~dir_q;
                        st_q  <= hsc_pkg::ST_EDGE;
                    end
                    else if (lim_hit)
                    begin
                        if (func == hsc_pkg::FUNC_MOMENTARY)
                            dir_q <= ~dir_q;
                        else
                            st_q <= hsc_pkg::ST_ERROR;
                    end
                hsc_pkg::ST_BACKOFF:
                    if (!lim_hit && !pin_b_q[2] && !pin_b_q[3])
                    begin
                        if (use_idx)
                            st_q <= hsc_pkg::ST_INDEX;
                        else
                        begin
                            home_pos_q <= POS_ACTUAL;
                            st_q <= hsc_pkg::ST_FINISH;
                        end
                    end
                hsc_pkg::ST_EDGE:
                    // A rising edge is only met from outside the switch, so leave and come back.
                    if (func == hsc_pkg::FUNC_MOMENTARY && !cfg_q[hsc_pkg::CFG_HNEG_BIT] &&
                        home_fall)
                        dir_q <= ~dir_q;
                    else if ((func == hsc_pkg::FUNC_MOMENTARY) ? home_sel : !home_lvl)
                    begin
                        if (use_idx)
                        begin
                            // Bit 6 set turns back to the initial direction for the index.
                            if (cfg_q[hsc_pkg::CFG_ISIDE_BIT])
                                dir_q <= cfg_q[hsc_pkg::CFG_DIR_BIT];
                            st_q <= hsc_pkg::ST_INDEX;
                        end
                        else
                        begin
                            home_pos_q <= POS_ACTUAL;
                            st_q <= hsc_pkg::ST_FINISH;
                        end
                    end
                hsc_pkg::ST_PRESS:
                    if (dly_cnt_q >= dly_target)
                    begin
                        if (use_idx)
                        begin
                            dir_q <= ~dir_q;
                            st_q  <= hsc_pkg::ST_INDEX;
                        end
                        else
                        begin
                            home_pos_q <= POS_ACTUAL;
                            st_q <= hsc_pkg::ST_FINISH;
                        end
                    end
                    else
                        dly_cnt_q <= dly_cnt_q + 32'h1;
                hsc_pkg::ST_INDEX:
                    if (idx_edge)
                    begin
                        home_pos_q <= POS_ACTUAL;
                        st_q <= hsc_pkg::ST_FINISH;
                    end
                hsc_pkg::ST_FINISH:
                    st_q <= (cfg_q[hsc_pkg::CFG_MOVE0_BIT] && !noadj) ?
                            hsc_pkg::ST_MOVE0 : hsc_pkg::ST_IDLE;
                hsc_pkg::ST_MOVE0:
                    if (zero_done)
                        st_q <= hsc_pkg::ST_IDLE;
                hsc_pkg::ST_ERROR:
                    if (start)
                        st_q <= hsc_pkg::ST_IDLE;
                default:
                    st_q <= hsc_pkg::ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // End of homing results
    // ************************************************************
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            adjust_q     <= 32'h0000_0000;
            zero_q       <= 32'h0000_0000;
            nv_cfg_q     <= hsc_pkg::CONFIG_RESET;
            nv_ofs_q     <= 32'h0000_0000;
            POS_LOAD     <= 1'b0;
            POS_LOAD_VAL <= '0;
        end
        else
        begin
            POS_LOAD <= 1'b0;
            if (st_q == hsc_pkg::ST_FINISH)
            begin
                zero_q   <= zero_calc;
                adjust_q <= zero_calc;
                // Actual position becomes distance from the new zero.
                POS_LOAD_VAL <= POS_W'(32'(POS_ACTUAL) - zero_calc);
                POS_LOAD <= !noadj;
                if (cfg_q[hsc_pkg::CFG_CAL_BIT])
                begin
                    nv_cfg_q <= hsc_pkg::CAL_CONFIG;
                    nv_ofs_q <= offset_q - zero_calc;
                end
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    wire [CUR_W+7:0] lim_calc = (CUR_W+8)'(CUR_THRESH) * (CUR_W+8)'(100 + hsc_pkg::CUR_MARGIN);

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            MOVE_EN      <= 1'b0;
            MOVE_NEG     <= 1'b0;
            SLOW         <= 1'b0;
            CUR_LIMIT    <= '0;
            CUR_LIMIT_EN <= 1'b0;
            GOTO_ZERO    <= 1'b0;
            BUSY         <= 1'b0;
            DONE         <= 1'b0;
            ERROR        <= 1'b0;
        end
        else
        begin
            MOVE_EN   <= st_q inside {hsc_pkg::ST_SEARCH, hsc_pkg::ST_BACKOFF,
                                      hsc_pkg::ST_EDGE, hsc_pkg::ST_PRESS, hsc_pkg::ST_INDEX};
            MOVE_NEG  <= dir_q;
            SLOW      <= st_q inside {hsc_pkg::ST_EDGE, hsc_pkg::ST_INDEX};
            CUR_LIMIT <= CUR_W'(lim_calc / (CUR_W+8)'(100));
            CUR_LIMIT_EN <= func == hsc_pkg::FUNC_HARDSTOP &&
                            st_q inside {hsc_pkg::ST_SEARCH, hsc_pkg::ST_PRESS};
            GOTO_ZERO <= st_q == hsc_pkg::ST_MOVE0;
            BUSY      <= !(st_q inside {hsc_pkg::ST_IDLE, hsc_pkg::ST_ERROR});
            ERROR     <= st_q == hsc_pkg::ST_ERROR;
            if (start)
                DONE <= 1'b0;
            else if (st_q == hsc_pkg::ST_FINISH)
                DONE <= 1'b1;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_bad_func;
        @(posedge CORE_CLK) disable iff (RST)
        (st_q == hsc_pkg::ST_IDLE && start && func > hsc_pkg::FUNC_HARDSTOP)
            |=> st_q == hsc_pkg::ST_ERROR ##1 ERROR;
    endproperty
    a_bad_func: assert property (p_bad_func) else $error("bad function not flagged");

    property p_dir;
        @(posedge CORE_CLK) disable iff (RST)
        (st_q == hsc_pkg::ST_IDLE && start && func inside {[4'h1:4'h4]})
            |=> dir_q == $past(cfg_q[hsc_pkg::CFG_DIR_BIT]) ##1
                MOVE_EN && MOVE_NEG == $past(cfg_q[hsc_pkg::CFG_DIR_BIT], 2);
    endproperty
    a_dir: assert property (p_dir) else $error("initial direction wrong");

    property p_lim_err;
        @(posedge CORE_CLK) disable iff (RST)
        (st_q == hsc_pkg::ST_SEARCH && func == hsc_pkg::FUNC_SWITCH && !home_lvl && lim_hit)
            |=> st_q == hsc_pkg::ST_ERROR;
    endproperty
    a_lim_err: assert property (p_lim_err) else $error("limit not error in function 2");

    property p_lim_rev;
        @(posedge CORE_CLK) disable iff (RST)
        (st_q == hsc_pkg::ST_SEARCH && func == hsc_pkg::FUNC_MOMENTARY && !home_lvl && lim_hit)
            |=> st_q == hsc_pkg::ST_SEARCH && dir_q != $past(dir_q);
    endproperty
    a_lim_rev: assert property (p_lim_rev) else $error("limit did not reverse");

    property p_noadj;
        @(posedge CORE_CLK) disable iff (RST)
        (st_q == hsc_pkg::ST_FINISH && noadj) |=> !POS_LOAD && st_q == hsc_pkg::ST_IDLE;
    endproperty
    a_noadj: assert property (p_noadj) else $error("position adjusted or move made");

    property p_move0;
        @(posedge CORE_CLK) disable iff (RST)
        (st_q == hsc_pkg::ST_FINISH && cfg_q[hsc_pkg::CFG_MOVE0_BIT] && !noadj)
            |=> ##1 GOTO_ZERO;
    endproperty
    a_move0: assert property (p_move0) else $error("no move to zero");

    property p_cal;
        @(posedge CORE_CLK) disable iff (RST)
        (st_q == hsc_pkg::ST_FINISH && cfg_q[hsc_pkg::CFG_CAL_BIT]) |=> nv_cfg_q == 16'h000f;
    endproperty
    a_cal: assert property (p_cal) else $error("stored config not 15");

    property p_zero;
        @(posedge CORE_CLK) disable iff (RST)
        (st_q == hsc_pkg::ST_FINISH) |=> zero_q == 32'($past(home_pos_q)) + $past(offset_q);
    endproperty
    a_zero: assert property (p_zero) else $error("zero not home plus offset");

    c_switch: cover property (@(posedge CORE_CLK) disable iff (RST)
        st_q == hsc_pkg::ST_EDGE ##[1:200] st_q == hsc_pkg::ST_FINISH);
    c_hard: cover property (@(posedge CORE_CLK) disable iff (RST)
        st_q == hsc_pkg::ST_PRESS ##1 st_q == hsc_pkg::ST_INDEX);
    c_err: cover property (@(posedge CORE_CLK) disable iff (RST) $rose(ERROR));

endmodule
`default_nettype wire

// file: logic/hsc_pkg.sv
// Package of constants and types for the homing sequencer.
`default_nettype none
package hsc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] ADDR_CONFIG  = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_STATUS  = 4'h2;
    localparam logic [3:0] ADDR_OFFSET  = 4'h3;
    localparam logic [3:0] ADDR_DELAY   = 4'h4;
    localparam logic [3:0] ADDR_ADJUST  = 4'h5;
    localparam logic [3:0] ADDR_NV_CFG  = 4'h6;
    localparam logic [3:0] ADDR_NV_OFS  = 4'h7;
    localparam logic [3:0] ADDR_ZERO    = 4'h8;

    // ************************************************************
    // Configuration word fields
    // ************************************************************
    localparam int CFG_FUNC_LSB  = 0;
    localparam int CFG_DIR_BIT   = 4;
    localparam int CFG_INDEX_BIT = 5;
    localparam int CFG_ISIDE_BIT = 6;
    localparam int CFG_IFALL_BIT = 7;
    localparam int CFG_HNEG_BIT  = 8;
    localparam int CFG_MOVE0_BIT = 9;
    localparam int CFG_NOADJ_BIT = 10;
    localparam int CFG_CAL_BIT   = 11;

    localparam logic [3:0] FUNC_IMMEDIATE = 4'h0;
    localparam logic [3:0] FUNC_LIMIT     = 4'h1;
    localparam logic [3:0] FUNC_SWITCH    = 4'h2;
    localparam logic [3:0] FUNC_MOMENTARY = 4'h3;
    localparam logic [3:0] FUNC_HARDSTOP  = 4'h4;

    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] CAL_CONFIG   = 16'h000f;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ     = 20000000;
    localparam int MS_CYCLES  = CLK_HZ / 1000;
    localparam int CUR_MARGIN = 25;

    typedef enum logic [3:0] {
        ST_IDLE, ST_SEARCH, ST_BACKOFF, ST_EDGE, ST_PRESS, ST_INDEX,
        ST_FINISH, ST_MOVE0, ST_ERROR
    } hsc_state_t;

endpackage
`default_nettype wire

// file: sim/hsc_motor_model.sv
// Behavioural model of the motor, encoder index, home switch and limit switches.
`timescale 1ns/1ns
`default_nettype none
module hsc_motor_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Drive commands
    input  wire logic        move_en,
    input  wire logic        move_neg,
    input  wire logic        goto_zero,
    input  wire logic        pos_load,
    input  wire logic [31:0] pos_load_val,
    // Feedback
    output logic      [31:0] pos,
    output logic      [15:0] cur,
    output logic             index_out,
    output logic             home_out,
    output logic             lim_pos,
    output logic             lim_neg,
    output logic             zero_hit
);
    // ************************************************************
    // Axis geometry
    // ************************************************************
    // The hard stop sits inside the negative limit, so hard-stop homing never trips it.
    localparam int HOME_LO = -100;
    localparam int HOME_HI = -90;
    localparam int LIM_P   = 300;
    localparam int LIM_N   = -300;
    localparam int STOP    = -250;

    logic stalled;

    assign stalled   = move_en && move_neg && ($signed(pos) <= STOP);
    assign cur       = stalled ? 16'h0140 : 16'h0000;
    assign index_out = (pos[3:0] == 4'h0);
    assign home_out  = ($signed(pos) >= HOME_LO) && ($signed(pos) <= HOME_HI);
    assign lim_pos   = ($signed(pos) >= LIM_P);
    assign lim_neg   = ($signed(pos) <= LIM_N);
    // Zero is reported reached at once; the move itself is not modelled.
    assign zero_hit  = goto_zero;

    // ************************************************************
    // Position, one count per cycle while moving
    // ************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pos <= 32'h0000_0000;
        else if (pos_load)
            pos <= pos_load_val;
        else if (move_en && !stalled)
            pos <= move_neg ? pos - 32'h0000_0001 : pos + 32'h0000_0001;
    end
endmodule
`default_nettype wire

// file: sim/tb_homing_sequence_configuration.sv
// Self-checking testbench for the homing sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb_homing_sequence_configuration;
    logic        core_clk, rst, wr, rd, move_en, move_neg, slow, goto_zero, pos_load;
    logic        idx, home, lp, ln, zr, busy, done, error, lim_en;
    logic        saw_load, saw_goto, saw_neg, saw_slow;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, pos, pos_load_val, r;
    logic [15:0] cur, thresh, cur_lim, lim_seen;
    int          mismatches, n_compared;

    hsc_top u_dut (.CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .POS_ACTUAL(pos), .CUR_ACTUAL(cur), .CUR_THRESH(thresh),
        .MOVE_EN(move_en), .MOVE_NEG(move_neg), .SLOW(slow), .CUR_LIMIT(cur_lim),
        .CUR_LIMIT_EN(lim_en), .GOTO_ZERO(goto_zero), .POS_LOAD(pos_load),
        .POS_LOAD_VAL(pos_load_val), .INDEX_PIN(idx), .HOME_PIN(home), .LIM_POS_PIN(lp),
        .LIM_NEG_PIN(ln), .ZERO_REACHED(zr), .BUSY(busy), .DONE(done), .ERROR(error));

    hsc_motor_model u_motor (.clk(core_clk), .rst(rst), .move_en(move_en),
        .move_neg(move_neg), .goto_zero(goto_zero), .pos_load(pos_load),
        .pos_load_val(pos_load_val), .pos(pos), .cur(cur), .index_out(idx),
        .home_out(home), .lim_pos(lp), .lim_neg(ln), .zero_hit(zr));

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        if (rst === 1'b1)
        begin
            saw_load <= 1'b0;
            saw_goto <= 1'b0;
            saw_neg  <= 1'b0;
            saw_slow <= 1'b0;
            lim_seen <= 16'h0000;
        end
        else
        begin
            if (pos_load === 1'b1) saw_load <= 1'b1;
            if (goto_zero === 1'b1) saw_goto <= 1'b1;
            if (move_en === 1'b1 && move_neg === 1'b1) saw_neg <= 1'b1;
            if (slow === 1'b1) saw_slow <= 1'b1;
            if (lim_en === 1'b1) lim_seen <= cur_lim;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 r = rdata;
    endtask

    // Each run starts from reset so the axis is back at position zero.
    task automatic run_home(input logic [15:0] cfg, input logic [31:0] ofs);
        int n;
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        wr_reg(hsc_pkg::ADDR_CONFIG, {16'h0000, cfg});
        wr_reg(hsc_pkg::ADDR_OFFSET, ofs);
        wr_reg(hsc_pkg::ADDR_DELAY, 32'h0000_0000);
        wr_reg(hsc_pkg::ADDR_CONTROL, 32'h0000_0001);
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1 n++;
        end
        while (done !== 1'b1 && error !== 1'b1 && n < 5000);
        // The move to zero trails the done flag by a few cycles; the position load comes in the same cycle as done.
        repeat (8) @(posedge core_clk);
        #1 chk({31'h0, done === 1'b1 || error === 1'b1}, 32'h1);
        chk({31'h0, busy}, 32'h0);
    endtask

    task automatic s_regs();
        rd_reg(hsc_pkg::ADDR_CONFIG);
        chk(r, 32'h0000_0000);
        wr_reg(hsc_pkg::ADDR_CONFIG, 32'h0000_0a5a);
        rd_reg(hsc_pkg::ADDR_CONFIG);
        chk(r, 32'h0000_0a5a);
        rd_reg(4'hf);
        chk(r, 32'h0000_0000);
    endtask

    task automatic s_zero_cal();
        run_home(16'h0a00, 32'h0000_0005);
        chk({31'h0, done}, 32'h1);
        chk({31'h0, saw_goto}, 32'h1);
        rd_reg(hsc_pkg::ADDR_ZERO);
        chk(r, 32'h0000_0005);
        chk(pos, 32'hffff_fffb);
        rd_reg(hsc_pkg::ADDR_NV_CFG);
        chk(r, 32'h0000_000f);
        rd_reg(hsc_pkg::ADDR_NV_OFS);
        chk(r, 32'h0000_0000);
    endtask

    task automatic s_no_adjust();
        run_home(16'h0600, 32'h0000_0005);
        chk({31'h0, saw_load}, 32'h0);
        chk(pos, 32'h0000_0000);
        chk({31'h0, saw_goto}, 32'h0);
        rd_reg(hsc_pkg::ADDR_ADJUST);
        chk(r, 32'h0000_0005);
    endtask

    task automatic s_switch();
        run_home(16'h0002, 32'h0000_0000);
        chk({31'h0, error}, 32'h1);
        run_home(16'h0012, 32'h0000_0000);
        chk({31'h0, done}, 32'h1);
        chk({31'h0, saw_neg}, 32'h1);
        rd_reg(hsc_pkg::ADDR_ZERO);
        chk({31'h0, $signed(r) > -100 && $signed(r) < -80}, 32'h1);
        run_home(16'h0032, 32'h0000_0000);
        chk({31'h0, done}, 32'h1);
        chk({31'h0, saw_slow}, 32'h1);
        rd_reg(hsc_pkg::ADDR_ZERO);
        chk({31'h0, $signed(r) > -90 && $signed(r) < -70}, 32'h1);
        run_home(16'h0072, 32'h0000_0000);
        rd_reg(hsc_pkg::ADDR_ZERO);
        chk({31'h0, $signed(r) < -90 && $signed(r) > -110}, 32'h1);
        run_home(16'h0003, 32'h0000_0000);
        chk({31'h0, done}, 32'h1);
        rd_reg(hsc_pkg::ADDR_ZERO);
        chk({31'h0, $signed(r) < -90 && $signed(r) > -100}, 32'h1);
        run_home(16'h0103, 32'h0000_0000);
        rd_reg(hsc_pkg::ADDR_ZERO);
        chk({31'h0, $signed(r) > -90 && $signed(r) < -80}, 32'h1);
    endtask

    task automatic s_hard_stop();
        run_home(16'h0014, 32'h0000_0000);
        chk({31'h0, done}, 32'h1);
        chk({16'h0, lim_seen}, 32'h0000_0140);
        chk({31'h0, saw_slow}, 32'h0);
        run_home(16'h0034, 32'h0000_0000);
        rd_reg(hsc_pkg::ADDR_ZERO);
        chk({31'h0, $signed(r) > -250 && $signed(r) < -230}, 32'h1);
        run_home(16'h0005, 32'h0000_0000);
        chk({31'h0, error}, 32'h1);
    endtask

    task automatic report_and_stop();
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #4000000;
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        thresh = 16'h0100;
        mismatches = 0;
        n_compared = 0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        s_regs();
        s_zero_cal();
        s_no_adjust();
        s_switch();
        s_hard_stop();
        report_and_stop();
    end
endmodule
`default_nettype wire
